// File: tcp_partner.sv
`timescale 1ns/1ps
module tcp_partner
  import tcp_pkg::*;
#(
  parameter int HI = 8,
  parameter int LO = 4
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic go_i,
  output logic      timer_in_o,
  output logic      busy_o
);
  int cnt_reg;
  // both phases well over the two clocks the synchroniser needs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 0;
    end else if (go_i && cnt_reg == 0) begin
      cnt_reg <= HI + LO;
    end else if (cnt_reg != 0) begin
      cnt_reg <= cnt_reg - 1;
    end
  end
  assign timer_in_o = cnt_reg > LO;
  assign busy_o     = cnt_reg != 0;
endmodule : tcp_partner

// File: tcp_pkg.sv
package tcp_pkg;

  localparam int          CNT_W       = 16;
  localparam int          ADDR_W      = 5;
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] CNT_RST     = 16'h0001;
  localparam logic [15:0] RELOAD_RST  = 16'hffff;
  localparam logic [15:0] MATCH_RST   = 16'h0000;

  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_COUNT  = 5'h04;
  localparam logic [4:0] OFF_RELOAD = 5'h08;
  localparam logic [4:0] OFF_MATCH  = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_MASK   = 5'h14;
  localparam logic [4:0] OFF_PINS   = 5'h18;

  localparam int EV_RELOAD  = 0;
  localparam int EV_CAPTURE = 1;
  localparam int EV_W       = 2;

  typedef enum logic [1:0] {
    TCP_MODE_COUNTER = 2'b00,
    TCP_MODE_PWM     = 2'b01,
    TCP_MODE_CAPTURE = 2'b10
  } tcp_mode_e;

  // control word, low bits of the control register
  typedef struct packed {
    logic [2:0] prescale;
    logic       output_polarity_select;
    logic [1:0] mode;
    logic       enable;
  } tcp_ctrl_s;

  localparam int        CTRL_W   = 7;
  localparam tcp_ctrl_s CTRL_RST = 7'h00;

endpackage : tcp_pkg

// File: tcp_prescaler.sv
`timescale 1ns/1ps
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int SEL_W = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  tick_o
);

  localparam int DIV_W = (1 << SEL_W) - 1;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [DIV_W-1:0] mask;

  generate
    if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel
      $error("tcp_prescaler: SEL_W must be 1 to 4");
    end
  endgenerate

  // factor is 2**sel; sel of zero ticks every cycle
  assign mask     = DIV_W'((1 << sel_i) - 1);
  assign tick_o   = run_i && ((div_reg & mask) == mask);
  assign div_next = run_i ? div_reg + DIV_W'(1) : '0;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule : tcp_prescaler

// File: tcp_sync2.sv
`timescale 1ns/1ps
module tcp_sync2
  import tcp_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_o   <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : tcp_sync2

// File: tcp_timer.sv
`timescale 1ns/1ps
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int PRE_SEL_W = 3
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              timer_in_i,
  output logic                   timer_out_o,
  output logic                   irq_o
);

  generate
    if (PRE_SEL_W != 3) begin : g_bad_pre
      $error("tcp_timer: control layout holds a 3-bit prescale");
    end
  endgenerate

  // bus handshake
  logic        ack_reg;
  logic        req;
  logic        wr_ack;
  logic        rd_ack;
  logic [31:0] rdata_next;
  logic [31:0] wmask;

  // registers
  tcp_ctrl_s      ctrl_reg;
  tcp_ctrl_s      ctrl_next;
  logic [15:0]    count_reg;
  logic [15:0]    count_next;
  logic [15:0]    reload_reg;
  logic [15:0]    reload_next;
  logic [15:0]    match_reg;
  logic [15:0]    match_next;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic           out_reg;
  logic           out_next;
  logic           in_prev_reg;

  // decode
  logic wr_ctrl;
  logic wr_count;
  logic wr_reload;
  logic wr_match;
  logic wr_status;
  logic wr_mask;

  // timer datapath
  logic        in_sync;
  logic        rise;
  logic        fall;
  logic        sel_edge;
  logic        pre_tick;
  logic        running;
  logic        is_counter;
  logic        is_pwm;
  logic        is_capture;
  logic        step;
  logic        at_reload;
  logic [15:0] count_inc;
  logic        hit_match;
  logic        ev_reload;
  logic        ev_capture;
  logic [EV_W-1:0] ev_set;

  tcp_sync2 u_in_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (timer_in_i),
    .sync_o    (in_sync)
  );

  tcp_prescaler #(
    .SEL_W (PRE_SEL_W)
  ) u_prescaler (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (running && !is_counter),
    .sel_i     (ctrl_reg.prescale),
    .tick_o    (pre_tick)
  );

  // ---- avalon slave: one wait state on every access ----
  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_reg;
  assign wr_ack            = avs_write_i && ack_reg;
  assign rd_ack            = avs_read_i && ack_reg;

  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  assign wr_ctrl   = wr_ack && (avs_address_i == OFF_CTRL);
  assign wr_count  = wr_ack && (avs_address_i == OFF_COUNT);
  assign wr_reload = wr_ack && (avs_address_i == OFF_RELOAD);
  assign wr_match  = wr_ack && (avs_address_i == OFF_MATCH);
  assign wr_status = wr_ack && (avs_address_i == OFF_STATUS);
  assign wr_mask   = wr_ack && (avs_address_i == OFF_MASK);

  // unmapped offsets read zero and ignore writes
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address_i)
      OFF_CTRL:   rdata_next[CTRL_W-1:0] = ctrl_reg;
      OFF_COUNT:  rdata_next[15:0]       = count_reg;
      OFF_RELOAD: rdata_next[15:0]       = reload_reg;
      OFF_MATCH:  rdata_next[15:0]       = match_reg;
      OFF_STATUS: rdata_next[EV_W-1:0]   = status_reg;
      OFF_MASK:   rdata_next[EV_W-1:0]   = mask_reg;
      OFF_PINS:   rdata_next[1:0]        = {in_sync, out_reg};
      default:    rdata_next             = 32'h0000_0000;
    endcase
  end

  // ---- mode and edge decode ----
  assign running    = ctrl_reg.enable;
  assign is_counter = ctrl_reg.mode == TCP_MODE_COUNTER;
  assign is_pwm     = ctrl_reg.mode == TCP_MODE_PWM;
  assign is_capture = ctrl_reg.mode == TCP_MODE_CAPTURE;
  assign rise       = in_sync && !in_prev_reg;
  assign fall       = !in_sync && in_prev_reg;
  // polarity one picks the rising edge
  assign sel_edge   = ctrl_reg.output_polarity_select ? rise : fall;

  // count source per mode
  assign step = running && (is_counter ? sel_edge : pre_tick);

  assign at_reload = count_reg == reload_reg;
  assign count_inc = count_reg + 16'h0001;
  // output toggles on the step that leaves the match count, so the first level lasts match ticks
  assign hit_match = step && !at_reload && (count_reg == match_reg);
  assign ev_reload  = step && at_reload;
  assign ev_capture = running && is_capture && sel_edge;

  always_comb begin
    ev_set             = '0;
    ev_set[EV_RELOAD]  = ev_reload;
    ev_set[EV_CAPTURE] = ev_capture;
  end

  // ---- next-state logic ----
  assign ctrl_next = wr_ctrl
                   ? tcp_ctrl_s'(avs_writedata_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]
                                 | ctrl_reg & ~wmask[CTRL_W-1:0])
                   : ctrl_reg;

  assign reload_next = wr_reload
                     ? (avs_writedata_i[15:0] & wmask[15:0]) | (reload_reg & ~wmask[15:0])
                     : reload_reg;

  assign mask_next = wr_mask
                   ? (avs_writedata_i[EV_W-1:0] & wmask[EV_W-1:0])
                     | (mask_reg & ~wmask[EV_W-1:0])
                   : mask_reg;

  // a software load is the start value; after a reload the count restarts at 0001h
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = (avs_writedata_i[15:0] & wmask[15:0]) | (count_reg & ~wmask[15:0]);
    end else if (ev_reload) begin
      count_next = CNT_RESTART;
    end else if (step) begin
      count_next = count_inc;
    end
  end

  // capture wins over a software write in the same cycle
  always_comb begin
    match_next = match_reg;
    if (ev_capture) begin
      match_next = count_reg;
    end else if (wr_match) begin
      match_next = (avs_writedata_i[15:0] & wmask[15:0]) | (match_reg & ~wmask[15:0]);
    end
  end

  // sticky events: set beats a write-one-to-clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & ~(avs_writedata_i[EV_W-1:0] & wmask[EV_W-1:0]);
    end
    status_next = status_next | ev_set;
  end

  // output level: idle holds the polarity, pwm toggles on match and restores at reload
  always_comb begin
    out_next = out_reg;
    if (!running) begin
      out_next = ctrl_reg.output_polarity_select;
    end else if (is_pwm && ev_reload) begin
      out_next = ctrl_reg.output_polarity_select;
    end else if (is_pwm && hit_match) begin
      out_next = !out_reg;
    end else if (is_counter && ev_reload) begin
      out_next = !out_reg;
    end
  end

  assign irq_o       = |(status_reg & mask_reg);
  assign timer_out_o = out_reg;

  // ---- registers ----
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_reg        <= req && !ack_reg;
      avs_readdata_o <= rd_ack ? avs_readdata_o : rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg   <= CTRL_RST;
      reload_reg <= RELOAD_RST;
      mask_reg   <= '0;
    end else begin
      ctrl_reg   <= ctrl_next;
      reload_reg <= reload_next;
      mask_reg   <= mask_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg   <= CNT_RST;
      match_reg   <= MATCH_RST;
      status_reg  <= '0;
      out_reg     <= 1'b0;
      in_prev_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      match_reg   <= match_next;
      status_reg  <= status_next;
      out_reg     <= out_next;
      in_prev_reg <= in_sync;
    end
  end

endmodule : tcp_timer

// File: tcp_timer_checker.sv
`timescale 1ns/1ps
module tcp_timer_checker
  import tcp_pkg::*;
#(
  parameter int PRE_SEL_W = 3
) (
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              timer_in_i,
  input wire logic              timer_out_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  tcp_ctrl_s  ctrl_reg;
  logic [1:0] mask_reg;
  logic [1:0] calm_reg;
  wire wr_ack  = avs_write_i && !avs_waitrequest_o;
  wire ctrl_wr = wr_ack && avs_address_i == OFF_CTRL && avs_byteenable_i[0];
  wire mask_wr = wr_ack && avs_address_i == OFF_MASK && avs_byteenable_i[0];
  // shadow copies rebuilt from acked writes, as the checker sees only ports
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= 2'h0;
      calm_reg <= 2'h0;
    end else begin
      if (ctrl_wr) ctrl_reg <= avs_writedata_i[CTRL_W-1:0];
      if (mask_wr) mask_reg <= avs_writedata_i[1:0];
      calm_reg <= ctrl_wr ? 2'h0 : (calm_reg == 2'h3 ? 2'h3 : calm_reg + 2'h1);
    end
  end
  sequence req_wait_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence rd_ack_s;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("new request got no wait state");
  wait_one_a: assert property (req_wait_s |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  wait_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");
  upper_zero_a: assert property (rd_ack_s |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (rd_ack_s ##0 (avs_address_i > OFF_PINS) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  idle_level_a: assert property (calm_reg == 2'h3 && !ctrl_reg.enable |-> timer_out_o == ctrl_reg.output_polarity_select)
    else $error("idle output differs from polarity");
  out_move_a: assert property ($changed(timer_out_o) |-> ctrl_reg.enable || calm_reg != 2'h3)
    else $error("output moved while timer stopped");
  irq_mask_a: assert property ($rose(irq_o) |-> mask_reg != 2'h0)
    else $error("interrupt rose with all events masked");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_ack))
    else $error("interrupt fell without a write");
endmodule : tcp_timer_checker

bind tcp_timer tcp_timer_checker #(.PRE_SEL_W(PRE_SEL_W)) chk_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .timer_in_i(timer_in_i),
  .timer_out_o(timer_out_o), .irq_o(irq_o));

// File: test_timer_counter_pwm_capture.sv
`timescale 1ns/1ps
module test_timer_counter_pwm_capture
  import tcp_pkg::*;
;
  logic              sys_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = 5'h00;
  logic              avs_read_i = 1'b0;
  logic              avs_write_i = 1'b0;
  logic [31:0]       avs_writedata_i = 32'h0;
  logic [3:0]        avs_byteenable_i = 4'hf;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              timer_in_i;
  logic              timer_out_o;
  logic              irq_o;
  logic              go_i = 1'b0;
  logic              busy_o;
  int                err_count = 0;
  int                num_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  tcp_timer #(.PRE_SEL_W(3)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .timer_in_i(timer_in_i), .timer_out_o(timer_out_o), .irq_o(irq_o));
  tcp_partner #(.HI(8), .LO(4)) pin_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go_i),
    .timer_in_o(timer_in_i), .busy_o(busy_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    chk(avs_readdata_o, exp);
    avs_read_i <= 1'b0;
  endtask : rc
  task automatic pulse;
    @(posedge sys_clk_i);
    go_i <= 1'b1;
    @(posedge sys_clk_i);
    go_i <= 1'b0;
    do @(posedge sys_clk_i); while (busy_o === 1'b1);
    cyc(4);
  endtask : pulse
  task automatic t_reset;
    rc(OFF_CTRL, 32'h0);
    rc(OFF_COUNT, {16'h0, CNT_RST});
    rc(OFF_RELOAD, {16'h0, RELOAD_RST});
    rc(OFF_MATCH, {16'h0, MATCH_RST});
    rc(OFF_STATUS, 32'h0);
    rc(OFF_MASK, 32'h0);
    rc(5'h1c, 32'h0);
    rc(OFF_PINS, 32'h0);
    wr(OFF_RELOAD, 32'h1234, 4'h0);
    rc(OFF_RELOAD, 32'hffff);
  endtask : t_reset
  task automatic t_counter;
    wr(OFF_CTRL, 32'h08, 4'h1);
    cyc(4);
    chk(timer_out_o, 1'b1);
    rc(OFF_PINS, 32'h1);
    wr(OFF_COUNT, 32'h2, 4'h3); // start off 0001h on purpose
    wr(OFF_RELOAD, 32'h3, 4'h3);
    wr(OFF_CTRL, 32'h09, 4'h1);
    pulse;
    rc(OFF_COUNT, 32'h3);
    repeat (3) pulse;
    rc(OFF_COUNT, 32'h3);
    rc(OFF_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h3, 4'h1);
    wr(OFF_CTRL, 32'h0, 4'h1);
  endtask : t_counter
  task automatic t_pwm(input logic pol);
    int          n_a;
    int          n_b;
    logic [31:0] c;
    n_a = 0;
    n_b = 0;
    c = {25'h0, 3'h1, pol, 2'b01, 1'b0};
    wr(OFF_CTRL, c, 4'h1);
    wr(OFF_COUNT, 32'h4, 4'h3);
    wr(OFF_MATCH, 32'h2, 4'h3);
    wr(OFF_RELOAD, 32'h6, 4'h3);
    wr(OFF_MASK, 32'h1, 4'h1);
    wr(OFF_CTRL, c | 32'h1, 4'h1);
    // first pass runs from the loaded start, so measure from a later reload
    for (int i = 0; i < 200 && timer_out_o !== ~pol; i++) @(posedge sys_clk_i);
    for (int i = 0; i < 200 && timer_out_o !== pol; i++) @(posedge sys_clk_i);
    while (timer_out_o === pol && n_a < 200) begin
      n_a++;
      @(posedge sys_clk_i);
    end
    while (timer_out_o === ~pol && n_b < 200) begin
      n_b++;
      @(posedge sys_clk_i);
    end
    chk(n_a, 4);
    chk(n_a + n_b, 12);
    chk(irq_o, 1'b1);
    wr(OFF_STATUS, 32'h1, 4'h1);
    cyc(1);
    chk(irq_o, 1'b0);
    wr(OFF_CTRL, c, 4'h1);
    wr(OFF_MASK, 32'h0, 4'h1);
  endtask : t_pwm
  task automatic t_capture;
    wr(OFF_CTRL, 32'h74, 4'h1);
    wr(OFF_COUNT, 32'h10, 4'h3);
    wr(OFF_STATUS, 32'h3, 4'h1);
    wr(OFF_CTRL, 32'h75, 4'h1);
    @(posedge sys_clk_i);
    go_i <= 1'b1;
    @(posedge sys_clk_i);
    go_i <= 1'b0;
    cyc(5);
    rc(OFF_STATUS, 32'h0);
    for (int i = 0; i < 50 && busy_o === 1'b1; i++) @(posedge sys_clk_i);
    cyc(4);
    rc(OFF_STATUS, 32'h2);
    // no prescaled tick yet at factor 128, so the capture holds the start count
    rc(OFF_MATCH, 32'h10);
    chk(irq_o, 1'b0);
    wr(OFF_MASK, 32'h2, 4'h1);
    cyc(1);
    chk(irq_o, 1'b1);
    wr(OFF_STATUS, 32'h2, 4'h1);
    cyc(1);
    chk(irq_o, 1'b0);
    wr(OFF_CTRL, 32'h0, 4'h1);
  endtask : t_capture
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    cyc(10);
    rst_i <= 1'b0;
    t_reset;
    t_counter;
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_capture;
    wrap_up;
  end
  // whole run needs well under a thousand cycles
  initial begin
    cyc(20000);
    err_count++;
    wrap_up;
  end
endmodule : test_timer_counter_pwm_capture
